/* hw/itm_period_meas.sv */
// Purpose: counts ticks between marks and latches the total at each mark
// Assumes: tick and mark are one-cycle pulses on the same clock
// Notes: saturates at all ones rather than wrapping
`timescale 1ns/1ps
`default_nettype none
module itm_period_meas #(
  parameter int W = 10
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_mark,
  output logic [W-1:0] o_value
);
  localparam logic [W-1:0] MAXV = '1;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] val;
  } itm_meas_t;

  itm_meas_t s_r;
  itm_meas_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (i_mark) begin
      // a tick on the mark cycle belongs to the new period
      s_nxt.val = s_r.cnt;
      s_nxt.cnt = i_tick ? {{(W-1){1'b0}}, 1'b1} : '0;
    end else if (i_tick && s_r.cnt != MAXV) begin
      s_nxt.cnt = s_r.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_value = s_r.val;

  property p_meas_latch;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_mark |=> o_value == $past(s_r.cnt);
  endproperty
  a_meas_latch: assert property (p_meas_latch) else $error("measure not latched at mark");

  property p_meas_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_mark |=> $stable(o_value);
  endproperty
  a_meas_hold: assert property (p_meas_hold) else $error("measure changed between marks");

  property p_meas_sat;
    @(posedge i_clk) disable iff (!i_rst_n)
    (s_r.cnt == MAXV && !i_mark) |=> s_r.cnt == MAXV;
  endproperty
  a_meas_sat: assert property (p_meas_sat) else $error("measure counter wrapped");
endmodule // itm_period_meas
`default_nettype wire

/* hw/itm_pkg.sv */
// Purpose: types of the input timing block
// Assumes: nothing
// Notes: one-hot serial port states
package itm_pkg;

  typedef enum logic [6:0] {
    ITM_S_IDLE = 7'b0000001,
    ITM_S_ADDR = 7'b0000010,
    ITM_S_AACK = 7'b0000100,
    ITM_S_WR = 7'b0001000,
    ITM_S_WACK = 7'b0010000,
    ITM_S_RD = 7'b0100000,
    ITM_S_RACK = 7'b1000000
  } itm_i2c_st_t;

  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic hs_q;
    logic vs_q;
    logic osc_q;
    itm_i2c_st_t st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic first;
    logic rw;
    logic sda_oe_n;
    logic sda_lvl;
    logic [10:0] spl;
    logic [7:0] vstage;
    logic [7:0] vact;
    logic [7:0] cmd;
  } itm_state_t;

endpackage

/* hw/itm_regs.svh */
// Purpose: register offsets, field positions and reset values of the input timing block
// Assumes: 8-bit registers at byte offsets, reached over the two-wire serial port
// Notes: definitions only
// Summary of operation
// - an 11-bit samples-per-line value is held as low byte plus 3-bit high field
// - samples-per-line value is the divider of the sampling-clock phase-locked loop
// - read-only 10-bit count of reference clocks in one incoming line
// - reference clock is the PAL or NTSC four-times-subcarrier oscillator as selected
// - read-only 12-bit count of incoming lines per frame
// - 8-bit vertical reduction coefficient m, scale 1-m/256, software keeps m at most 192
// - new coefficient takes effect only on any write to offset F
// - low command byte holds reset, four power-downs, notch, bandpass, pedestal at bits 0-7
// - pipeline-reset bit holds the video pipeline in reset; registers stay untouched
// - each power-down bit: 0 powers the function, 1 powers it off
// - filter bits insert filter when 1; pedestal bit inserts black pedestal when 1
`ifndef ITM_REGS_SVH
`define ITM_REGS_SVH

`define ITM_OFS_SPL_LO 8'h08
`define ITM_OFS_SPL_HI 8'h09
`define ITM_OFS_HLEN_LO 8'h0a
`define ITM_OFS_HLEN_HI 8'h0b
`define ITM_OFS_VCNT_LO 8'h0c
`define ITM_OFS_VCNT_HI 8'h0d
`define ITM_OFS_VCOEF 8'h0e
`define ITM_OFS_VLOAD 8'h0f
`define ITM_OFS_CMD 8'h10

`define ITM_CMD_PIPE_RST 0
`define ITM_CMD_CLK_DOWN 1
`define ITM_CMD_ADC_DOWN 2
`define ITM_CMD_COMP_DOWN 3
`define ITM_CMD_YC_DOWN 4
`define ITM_CMD_NOTCH 5
`define ITM_CMD_BANDPASS 6
`define ITM_CMD_PEDESTAL 7

`define ITM_RST_SPL 11'h000
`define ITM_RST_VCOEF 8'h00
`define ITM_RST_CMD 8'h00

`define ITM_I2C_BITS 4'h8

`endif

/* hw/itm_sync2.sv */
// Purpose: two-flop synchroniser for pins
// Assumes: inputs are independent levels
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module itm_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } itm_sync_t;

  itm_sync_t s_r;
  itm_sync_t s_nxt;

  always_comb begin
    s_nxt.meta = i_d;
    s_nxt.q = s_r.meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_q = s_r.q;
endmodule // itm_sync2
`default_nettype wire

/* hw/itm_top.sv */
// Purpose: input timing measure, samples-per-line, vertical coefficient and command byte
// Assumes: two-wire serial register port; syncs active high; oscillators far below i_mclk
// Notes: pointer byte then data, auto-increment; unmapped and write-only offsets read 0x00
`timescale 1ns/1ps
`include "itm_regs.svh"
`default_nettype none
module itm_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2a, // arbitrary
  parameter int HLEN_W = 10,
  parameter int VCNT_W = 12
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  input wire logic i_hsync,
  input wire logic i_vsync,
  input wire logic i_osc_pal,
  input wire logic i_osc_ntsc,
  input wire logic i_pal_select,
  output logic [10:0] o_spl_div,
  output logic [7:0] o_vert_coef,
  output logic o_pipe_reset,
  output logic o_core_clock_down,
  output logic o_input_converter_down,
  output logic o_composite_dac_down,
  output logic o_sep_video_dac_down,
  output logic o_luma_notch_on,
  output logic o_chroma_band_filter_on,
  output logic o_black_level_insert
);
  itm_pkg::itm_state_t s_r;
  itm_pkg::itm_state_t s_nxt;
  logic [5:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic hs_s;
  logic vs_s;
  logic osc_s;
  logic hs_rise;
  logic vs_rise;
  logic osc_rise;
  logic [HLEN_W-1:0] hlen;
  logic [VCNT_W-1:0] vcnt;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  logic we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  itm_sync2 #(.W(6)) u_sync (
    .i_clk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_d({i_scl, i_sda, i_hsync, i_vsync, i_osc_pal, i_osc_ntsc}),
    .o_q(pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  assign hs_s = pins_s[3];
  assign vs_s = pins_s[2];
  // switching standards may yield one stray edge; the next line corrects it
  assign osc_s = i_pal_select ? pins_s[1] : pins_s[0];

  assign hs_rise = hs_s & ~s_r.hs_q;
  assign vs_rise = vs_s & ~s_r.vs_q;
  assign osc_rise = osc_s & ~s_r.osc_q;
  assign scl_rise = scl_s & ~s_r.scl_q;
  assign scl_fall = ~scl_s & s_r.scl_q;
  assign start_ev = scl_s & s_r.scl_q & ~sda_s & s_r.sda_q;
  assign stop_ev = scl_s & s_r.scl_q & sda_s & ~s_r.sda_q;

  // reference clocks per line, latched at each line start
  itm_period_meas #(.W(HLEN_W)) u_hlen (
    .i_clk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_tick(osc_rise),
    .i_mark(hs_rise),
    .o_value(hlen)
  );

  // lines per frame, latched at each frame start
  itm_period_meas #(.W(VCNT_W)) u_vcnt (
    .i_clk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_tick(hs_rise),
    .i_mark(vs_rise),
    .o_value(vcnt)
  );

  always_comb begin
    case (s_r.ptr)
      `ITM_OFS_SPL_LO: rdata = s_r.spl[7:0];
      `ITM_OFS_SPL_HI: rdata = {5'h00, s_r.spl[10:8]};
      `ITM_OFS_HLEN_LO: rdata = hlen[7:0];
      `ITM_OFS_HLEN_HI: rdata = {6'h00, hlen[9:8]};
      `ITM_OFS_VCNT_LO: rdata = vcnt[7:0];
      `ITM_OFS_VCNT_HI: rdata = {4'h0, vcnt[11:8]};
      `ITM_OFS_VCOEF: rdata = s_r.vstage;
      `ITM_OFS_CMD: rdata = s_r.cmd;
      default: rdata = 8'h00;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    we = 1'b0;
    waddr = s_r.ptr;
    wdata = s_r.shreg;
    s_nxt.scl_q = scl_s;
    s_nxt.sda_q = sda_s;
    s_nxt.hs_q = hs_s;
    s_nxt.vs_q = vs_s;
    s_nxt.osc_q = osc_s;
    if (start_ev) begin
      s_nxt.st = itm_pkg::ITM_S_ADDR;
      s_nxt.bit_cnt = 4'h0;
      s_nxt.first = 1'b1;
      s_nxt.sda_oe_n = 1'b1;
    end else if (stop_ev) begin
      s_nxt.st = itm_pkg::ITM_S_IDLE;
      s_nxt.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      if (s_r.st == itm_pkg::ITM_S_ADDR || s_r.st == itm_pkg::ITM_S_WR) begin
        s_nxt.shreg = {s_r.shreg[6:0], sda_s};
        s_nxt.bit_cnt = 4'(s_r.bit_cnt + 4'h1);
      end
      // a master that does not acknowledge ends the read burst
      if (s_r.st == itm_pkg::ITM_S_RACK && sda_s) begin
        s_nxt.st = itm_pkg::ITM_S_IDLE;
      end
    end else if (scl_fall) begin
      case (s_r.st)
        itm_pkg::ITM_S_ADDR: begin
          if (s_r.bit_cnt == `ITM_I2C_BITS) begin
            if (s_r.shreg[7:1] == DEV_ADDR) begin
              s_nxt.st = itm_pkg::ITM_S_AACK;
              s_nxt.sda_oe_n = 1'b0;
              s_nxt.rw = s_r.shreg[0];
            end else begin
              s_nxt.st = itm_pkg::ITM_S_IDLE;
            end
          end
        end
        itm_pkg::ITM_S_AACK, itm_pkg::ITM_S_RACK: begin
          s_nxt.bit_cnt = 4'h0;
          if (s_r.rw) begin
            s_nxt.shreg = rdata;
            s_nxt.ptr = s_r.ptr + 8'h01;
            s_nxt.sda_oe_n = rdata[7];
            s_nxt.st = itm_pkg::ITM_S_RD;
          end else begin
            s_nxt.sda_oe_n = 1'b1;
            s_nxt.st = itm_pkg::ITM_S_WR;
          end
        end
        itm_pkg::ITM_S_WR: begin
          if (s_r.bit_cnt == `ITM_I2C_BITS) begin
            s_nxt.sda_oe_n = 1'b0;
            s_nxt.st = itm_pkg::ITM_S_WACK;
            if (s_r.first) begin
              s_nxt.ptr = s_r.shreg;
              s_nxt.first = 1'b0;
            end else begin
              we = 1'b1;
              s_nxt.ptr = s_r.ptr + 8'h01;
            end
          end
        end
        itm_pkg::ITM_S_WACK: begin
          s_nxt.sda_oe_n = 1'b1;
          s_nxt.bit_cnt = 4'h0;
          s_nxt.st = itm_pkg::ITM_S_WR;
        end
        itm_pkg::ITM_S_RD: begin
          if (s_r.bit_cnt == 4'h7) begin
            s_nxt.sda_oe_n = 1'b1;
            s_nxt.st = itm_pkg::ITM_S_RACK;
          end else begin
            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
            s_nxt.sda_oe_n = s_r.shreg[6];
            s_nxt.bit_cnt = 4'(s_r.bit_cnt + 4'h1);
          end
        end
        default: begin
          s_nxt.sda_oe_n = 1'b1;
        end
      endcase
    end
    if (we) begin
      case (waddr)
        `ITM_OFS_SPL_LO: s_nxt.spl[7:0] = wdata;
        `ITM_OFS_SPL_HI: s_nxt.spl[10:8] = wdata[2:0];
        `ITM_OFS_VCOEF: s_nxt.vstage = wdata;
        // the written data is ignored; any write moves the staged value into use
        `ITM_OFS_VLOAD: s_nxt.vact = s_r.vstage;
        `ITM_OFS_CMD: s_nxt.cmd = wdata;
        default: ;
      endcase
    end
  end

  // the pipeline-reset bit is only an output; it never clears these registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.st <= itm_pkg::ITM_S_IDLE;
      s_r.sda_oe_n <= 1'b1;
      s_r.spl <= `ITM_RST_SPL;
      s_r.vstage <= `ITM_RST_VCOEF;
      s_r.vact <= `ITM_RST_VCOEF;
      s_r.cmd <= `ITM_RST_CMD;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_sda_out = s_r.sda_lvl;
  assign o_sda_oe_n = s_r.sda_oe_n;
  assign o_spl_div = s_r.spl;
  assign o_vert_coef = s_r.vact;
  assign o_pipe_reset = s_r.cmd[`ITM_CMD_PIPE_RST];
  assign o_core_clock_down = s_r.cmd[`ITM_CMD_CLK_DOWN];
  assign o_input_converter_down = s_r.cmd[`ITM_CMD_ADC_DOWN];
  assign o_composite_dac_down = s_r.cmd[`ITM_CMD_COMP_DOWN];
  assign o_sep_video_dac_down = s_r.cmd[`ITM_CMD_YC_DOWN];
  assign o_luma_notch_on = s_r.cmd[`ITM_CMD_NOTCH];
  assign o_chroma_band_filter_on = s_r.cmd[`ITM_CMD_BANDPASS];
  assign o_black_level_insert = s_r.cmd[`ITM_CMD_PEDESTAL];

  property p_coef_hold;
    @(posedge i_mclk) disable iff (!i_rst_n)
    !(we && waddr == `ITM_OFS_VLOAD) |=> $stable(o_vert_coef);
  endproperty
  a_coef_hold: assert property (p_coef_hold) else $error("coefficient changed without load");

  property p_coef_load;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (we && waddr == `ITM_OFS_VLOAD) |=> o_vert_coef == $past(s_r.vstage);
  endproperty
  a_coef_load: assert property (p_coef_load) else $error("load did not apply staged value");

  property p_coef_stage;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (we && waddr == `ITM_OFS_VCOEF) |=> s_r.vstage == $past(wdata) && $stable(o_vert_coef);
  endproperty
  a_coef_stage: assert property (p_coef_stage) else $error("coefficient staging wrong");

  property p_spl_lo;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (we && waddr == `ITM_OFS_SPL_LO) |=> o_spl_div[7:0] == $past(wdata) ##1 $stable(o_spl_div);
  endproperty
  a_spl_lo: assert property (p_spl_lo) else $error("samples low byte not applied");

  property p_spl_hi;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (we && waddr == `ITM_OFS_SPL_HI) |=> o_spl_div[10:8] == $past(wdata[2:0]);
  endproperty
  a_spl_hi: assert property (p_spl_hi) else $error("divider high field not applied");

  property p_cmd_rst;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (we && waddr == `ITM_OFS_CMD) |=> o_pipe_reset == $past(wdata[0]) && $stable(o_spl_div);
  endproperty
  a_cmd_rst: assert property (p_cmd_rst) else $error("pipeline reset bit wrong");

  property p_cmd_pwr;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (we && waddr == `ITM_OFS_CMD) |=> {o_core_clock_down, o_input_converter_down,
      o_composite_dac_down, o_sep_video_dac_down} == $past({wdata[1], wdata[2], wdata[3], wdata[4]});
  endproperty
  a_cmd_pwr: assert property (p_cmd_pwr) else $error("power-down bits misplaced");

  property p_cmd_filt;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (we && waddr == `ITM_OFS_CMD) |=> {o_black_level_insert, o_chroma_band_filter_on,
      o_luma_notch_on} == $past(wdata[7:5]);
  endproperty
  a_cmd_filt: assert property (p_cmd_filt) else $error("filter bits misplaced");

  property p_cmd_hold;
    @(posedge i_mclk) disable iff (!i_rst_n)
    !(we && waddr == `ITM_OFS_CMD) |=> $stable(s_r.cmd);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command byte changed unwritten");

  property p_pipe_rst_keep;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (o_pipe_reset && !we) |=> $stable(o_spl_div) && $stable(o_vert_coef)
      && $stable(s_r.vstage);
  endproperty
  a_pipe_rst_keep: assert property (p_pipe_rst_keep) else $error("pipeline reset disturbed registers");

  // pulling sda low while scl is high would read as a start and corrupt a write
  property p_sda_low_scl;
    @(posedge i_mclk) disable iff (!i_rst_n)
    $changed(o_sda_oe_n) |-> o_sda_oe_n || !s_r.scl_q;
  endproperty
  a_sda_low_scl: assert property (p_sda_low_scl) else $error("sda pulled low while scl high");
endmodule // itm_top
`default_nettype wire

/* verif/itm_video_src.sv */
// Purpose: model of the graphics source: syncs and both subcarrier oscillators
// Assumes: hsync follows the selected oscillator, so a line spans a fixed edge count
// Notes: vsync rises mid-line so no hsync edge lands on it
`timescale 1ns/1ps
`default_nettype none
module itm_video_src #(
  parameter int LINE_OSC = 40,
  parameter int LONG_OSC = 1030,
  parameter int FRAME_LINES = 8
) (
  input wire logic i_pal_select,
  input wire logic i_long_line,
  output logic o_hsync,
  output logic o_vsync,
  output logic o_osc_pal,
  output logic o_osc_ntsc
);
  int n_osc = 0;
  int n_line = 0;
  int len = 0;
  wire logic osc_sel = i_pal_select ? o_osc_pal : o_osc_ntsc;
  initial begin
    o_osc_pal = 1'b0;
    forever #28.195 o_osc_pal = ~o_osc_pal;
  end
  initial begin
    o_osc_ntsc = 1'b0;
    forever #34.921 o_osc_ntsc = ~o_osc_ntsc;
  end
  // lines are timed from the falling edge, half a period away from the counted rising edge
  initial begin
    o_hsync = 1'b0;
    o_vsync = 1'b0;
    forever begin
      @(negedge osc_sel);
      // a long line outruns the 10-bit line counter
      len = i_long_line ? LONG_OSC : LINE_OSC;
      n_osc = (n_osc >= len - 1) ? 0 : n_osc + 1;
      if (n_osc == 0) begin
        n_line = (n_line == FRAME_LINES - 1) ? 0 : n_line + 1;
      end
      o_hsync = (n_osc < 4);
      if (n_osc == LINE_OSC / 2) begin
        o_vsync = (n_line == 0);
      end
    end
  end
endmodule // itm_video_src
`default_nettype wire

/* verif/tb.sv */
// Purpose: self-checking bench for the input timing block
// Assumes: serial port bit-banged at 8 mclk per phase, inputs moved at falling edge
// Notes: sda resolved as open drain with pull-up
`timescale 1ns/1ps
`include "itm_regs.svh"
`default_nettype none
module tb;
  localparam int LOSC = 40;
  localparam int FLN = 8;
  localparam logic [6:0] DEV = 7'h2a;
  logic i_mclk, i_rst_n, scl, sda_m, pal, hs, vs, op, on;
  logic o_sda_out, o_sda_oe_n;
  logic [10:0] spl;
  logic [7:0] vcoef;
  wire logic [7:0] cmd_o;
  logic long_ln;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  wire logic sda_w = sda_m & (o_sda_oe_n | o_sda_out);

  itm_top #(.DEV_ADDR(DEV)) itm_top_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(scl),
    .i_sda(sda_w), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .i_hsync(hs),
    .i_vsync(vs), .i_osc_pal(op), .i_osc_ntsc(on), .i_pal_select(pal), .o_spl_div(spl),
    .o_vert_coef(vcoef), .o_pipe_reset(cmd_o[0]), .o_core_clock_down(cmd_o[1]),
    .o_input_converter_down(cmd_o[2]), .o_composite_dac_down(cmd_o[3]),
    .o_sep_video_dac_down(cmd_o[4]), .o_luma_notch_on(cmd_o[5]),
    .o_chroma_band_filter_on(cmd_o[6]), .o_black_level_insert(cmd_o[7]));
  itm_video_src #(.LINE_OSC(LOSC), .FRAME_LINES(FLN)) itm_video_src_i (.i_pal_select(pal),
    .i_long_line(long_ln), .o_hsync(hs), .o_vsync(vs), .o_osc_pal(op), .o_osc_ntsc(on));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic results();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // run is about 66k cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 100000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask
  task automatic hp();
    repeat (8) @(negedge i_mclk);
  endtask
  // data moves only while scl is low, so no false start or stop is seen
  task automatic sbit(input logic b, output logic r);
    sda_m = b;
    hp();
    scl = 1'b1;
    hp();
    r = sda_w;
    scl = 1'b0;
    hp();
  endtask
  task automatic start();
    sda_m = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_m = 1'b0;
    hp();
    scl = 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_m = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_m = 1'b1;
    hp();
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) sbit(d[i], r);
    sbit(1'b1, r);
    chk("ack", 16'(r), 16'h0000);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    start();
    wbyte({DEV, 1'b0});
    wbyte(a);
    wbyte(d);
    stop();
  endtask
  // single byte read ends with a master nack
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic r;
    start();
    wbyte({DEV, 1'b0});
    wbyte(a);
    start();
    wbyte({DEV, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      sbit(1'b1, r);
      d[i] = r;
    end
    sbit(1'b1, r);
    stop();
    chk(nm, 16'(d), 16'(exp));
  endtask
  task automatic meas();
    rchk("line_len_lo", `ITM_OFS_HLEN_LO, 8'(LOSC));
    rchk("line_len_hi", `ITM_OFS_HLEN_HI, 8'h00);
    rchk("frame_lines_lo", `ITM_OFS_VCNT_LO, 8'(FLN));
    rchk("frame_lines_hi", `ITM_OFS_VCNT_HI, 8'h00);
  endtask

  initial begin
    i_rst_n = 1'b0;
    scl = 1'b1;
    sda_m = 1'b1;
    pal = 1'b1;
    long_ln = 1'b0;
    repeat (16) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    chk("spl_div", 16'(spl), 16'h0000);
    chk("cmd_pins", 16'(cmd_o), 16'h0000);
    reg_wr(`ITM_OFS_SPL_LO, 8'ha5);
    reg_wr(`ITM_OFS_SPL_HI, 8'hff);
    chk("spl_div", 16'(spl), 16'h07a5);
    rchk("samples_hi", `ITM_OFS_SPL_HI, 8'h07);
    rchk("samples_lo", `ITM_OFS_SPL_LO, 8'ha5);
    reg_wr(`ITM_OFS_VCOEF, 8'hc0);
    chk("vert_coef", 16'(vcoef), 16'h0000);
    rchk("coef", `ITM_OFS_VCOEF, 8'hc0);
    reg_wr(`ITM_OFS_VLOAD, 8'h5a);
    chk("vert_coef", 16'(vcoef), 16'h00c0);
    rchk("coef_load", `ITM_OFS_VLOAD, 8'h00);
    for (int i = 0; i < 8; i++) begin
      reg_wr(`ITM_OFS_CMD, 8'h01 << i);
      chk("cmd_pins", 16'(cmd_o), 16'(8'h01 << i));
      rchk("cmd", `ITM_OFS_CMD, 8'h01 << i);
    end
    reg_wr(`ITM_OFS_CMD, 8'h01);
    chk("spl_div", 16'(spl), 16'h07a5);
    rchk("coef", `ITM_OFS_VCOEF, 8'hc0);
    reg_wr(`ITM_OFS_CMD, 8'h00);
    chk("cmd_pins", 16'(cmd_o), 16'h0000);
    // 80 samples at the model's line rate gives a sampling clock of about 35 MHz
    reg_wr(`ITM_OFS_SPL_LO, 8'h50);
    reg_wr(`ITM_OFS_SPL_HI, 8'h00);
    chk("spl_div", 16'(spl), 16'h0050);
    reg_wr(`ITM_OFS_HLEN_LO, 8'hff);
    reg_wr(8'h20, 8'h33);
    rchk("unmapped", 8'h20, 8'h00);
    meas();
    pal = 1'b0;
    // two ntsc frames so the stray count from the switch is flushed
    repeat (10000) @(negedge i_mclk);
    meas();
    long_ln = 1'b1;
    // one complete long line must have been latched before the reads
    repeat (20000) @(negedge i_mclk);
    rchk("line_len_sat_lo", `ITM_OFS_HLEN_LO, 8'hff);
    rchk("line_len_sat_hi", `ITM_OFS_HLEN_HI, 8'h03);
    results();
  end
endmodule // tb
`default_nettype wire
